// ---- design/uart89_map.svh ----
// constants for the 8/9-bit serial port: control bit positions, control reset value, counts
// assumes inclusion by the package and the design file only
`ifndef UART89_MAP_SVH
`define UART89_MAP_SVH
// ==========================================================
// control register bit positions and reset value
`define U89_BIT_RXDONE   0
`define U89_BIT_TXDONE   1
`define U89_BIT_RX9      2
`define U89_BIT_TX9      3
`define U89_BIT_RXEN     4
`define U89_BIT_MPEN     5
`define U89_BIT_UNUSED   6
`define U89_BIT_MODE     7
`define U89_CTRL_RESET   8'h40
// ==========================================================
// baud timer and framing
`define U89_TIMER_TOP    8'hff
`define U89_DATA_BITS    4'h8
`define U89_FRAME8_LAST  4'h9
`define U89_FRAME9_LAST  4'ha
`define U89_DIV12_MID1   6'h17
`define U89_DIV12_MID2   6'h23
`define U89_PRESC_W      6
`define U89_DIV4_LAST    6'h03
`define U89_DIV12_LAST   6'h0b
`define U89_DIV48_LAST   6'h2f
`define U89_DIV8_LAST    3'h7
`endif

// ---- design/uart89_pkg.sv ----
// types shared by the 8/9-bit serial port
// assumes the constants header sits beside it
`include "uart89_map.svh"
package uart89_pkg;
    // ==========================================================
    // baud timer clock sources
    typedef enum logic [2:0] {
        SRC_SYS, SRC_DIV4, SRC_DIV12, SRC_DIV48, SRC_XOSC8, SRC_EXT
    } uart89_src_e;
    // ==========================================================
    // software access strobes with their data, and baud timer settings
    typedef struct packed {
        logic       dataWr;
        logic       dataRd;
        logic       ctrlWr;
        logic [7:0] wrData;
    } uart89_cpu_s;
    typedef struct packed {
        logic       timerRun;
        uart89_src_e src;
        logic [7:0] reload;
    } uart89_baud_s;
endpackage

// ---- design/uart89_serial_port.sv ----
// 8/9-bit serial port with buffered receive, multiprocessor filter and baud timer
// assumes cpu strobes on clk_sys; pins and external clocks are asynchronous
`include "uart89_map.svh"
module uart89_serial_port
    import uart89_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 resetn,
    // software side
    input  wire uart89_pkg::uart89_cpu_s  cpu,
    input  wire uart89_pkg::uart89_baud_s baud,
    input  wire logic                 intEnable,
    output logic [7:0]                serial_control_reg,
    output logic [7:0]                serial_data_buffer,
    output logic                      serialIrq,
    // pins and external clocks
    input  wire logic                 serial_in_pin,
    input  wire logic                 baud_timer_ext_input,
    input  wire logic                 xoscClk,
    output logic                      serial_out_pin
);
    import uart89_pkg::*;

    // ==========================================================
    // pin synchronisers
    logic [1:0] rxSync;
    logic [1:0] extSync;
    logic [1:0] xoscSync;
    logic       rxLine;
    logic       extPrev;
    logic       xoscPrev;
    // second stage only feeds logic; first stage never read elsewhere
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rxSync   <= 2'h3;
            extSync  <= 2'h0;
            xoscSync <= 2'h0;
            rxLine   <= 1'b1;
            extPrev  <= 1'b0;
            xoscPrev <= 1'b0;
        end else begin
            rxSync   <= {rxSync[0], serial_in_pin};
            extSync  <= {extSync[0], baud_timer_ext_input};
            xoscSync <= {xoscSync[0], xoscClk};
            rxLine   <= rxSync[1];
            extPrev  <= extSync[1];
            xoscPrev <= xoscSync[1];
        end
    end

    // ==========================================================
    // baud timer clock selection
    logic [`U89_PRESC_W-1:0] presc;
    logic [2:0]              xoscDiv;
    logic                    timerTick;
    logic                    xoscRise;
    assign xoscRise = xoscSync[1] & ~xoscPrev;
    // free-running prescaler; /48 wraps it so /4 and /12 divide evenly too
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            presc   <= '0;
            xoscDiv <= '0;
        end else begin
            presc   <= (presc == `U89_DIV48_LAST) ? '0 : presc + 1'b1;
            if (xoscRise) xoscDiv <= xoscDiv + 1'b1;
        end
    end
    always_comb begin
        case (baud.src)
            SRC_SYS:   timerTick = 1'b1;
            SRC_DIV4:  timerTick = (presc[1:0] == `U89_DIV4_LAST);
            SRC_DIV12: timerTick = (presc == `U89_DIV12_LAST) ||
                                   (presc == `U89_DIV12_MID1) ||
                                   (presc == `U89_DIV12_MID2) ||
                                   (presc == `U89_DIV48_LAST);
            SRC_DIV48: timerTick = (presc == `U89_DIV48_LAST);
            SRC_XOSC8: timerTick = xoscRise && (xoscDiv == `U89_DIV8_LAST);
            SRC_EXT:   timerTick = extSync[1] & ~extPrev;
            default:   timerTick = 1'b0;
        endcase
    end

    // ==========================================================
    // transmit and receive timers with halving stages
    logic [7:0] baud_timer_low;
    logic [7:0] rxTimer;
    logic       txHalf;
    logic       rxHalf;
    logic       txBitTick;
    logic       rxBitTick;
    logic       rxHalfTick;
    logic       startSeen;
    logic       txOvf;
    logic       rxOvf;
    // overflow every 256-reload input ticks
    assign txOvf = baud.timerRun && timerTick && (baud_timer_low == `U89_TIMER_TOP);
    assign rxOvf = baud.timerRun && timerTick && (rxTimer == `U89_TIMER_TOP);
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            baud_timer_low <= '0;
            txHalf         <= 1'b0;
        end else if (txOvf) begin
            baud_timer_low <= baud.reload;
            txHalf         <= ~txHalf;
        end else if (baud.timerRun && timerTick) begin
            baud_timer_low <= baud_timer_low + 1'b1;
        end
    end
    // the copy restarts on a start edge so receive is not tied to tx phase
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rxTimer <= '0;
            rxHalf  <= 1'b0;
        end else if (startSeen) begin
            rxTimer <= baud.reload;
            rxHalf  <= 1'b0;
        end else if (rxOvf) begin
            rxTimer <= baud.reload;
            rxHalf  <= ~rxHalf;
        end else if (baud.timerRun && timerTick) begin
            rxTimer <= rxTimer + 1'b1;
        end
    end
    assign txBitTick  = txOvf && txHalf;
    assign rxHalfTick = rxOvf && !rxHalf; // middle of a bit cell
    assign rxBitTick  = rxOvf && rxHalf;

    // ==========================================================
    // control register
    logic tx_done_flag;
    logic rx_done_flag;
    logic rx_ninth_bit;
    logic tx_ninth_bit;
    logic rx_enable;
    logic multiproc_enable;
    logic frame_mode_select;
    logic txDoneSet;
    logic rxLoad;
    logic rxNinthNew;
    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            {frame_mode_select, multiproc_enable, rx_enable} <= '0;
            {tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag} <= '0;
        end else begin
            if (cpu.ctrlWr) begin
                frame_mode_select <= cpu.wrData[`U89_BIT_MODE];
                multiproc_enable  <= cpu.wrData[`U89_BIT_MPEN];
                rx_enable         <= cpu.wrData[`U89_BIT_RXEN];
                tx_ninth_bit      <= cpu.wrData[`U89_BIT_TX9];
                rx_ninth_bit      <= cpu.wrData[`U89_BIT_RX9];
                tx_done_flag      <= cpu.wrData[`U89_BIT_TXDONE];
                rx_done_flag      <= cpu.wrData[`U89_BIT_RXDONE];
            end
            if (txDoneSet) tx_done_flag <= 1'b1;
            if (rxLoad) begin
                rx_done_flag <= 1'b1;
                rx_ninth_bit <= rxNinthNew;
            end
        end
    end

    // ==========================================================
    // transmitter
    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} uart89_tx_e;
    uart89_tx_e txState;
    logic [9:0] txShift;
    logic [3:0] txCount;
    logic [3:0] txLast;
    // start + 8 data (+ ninth) + stop
    assign txLast = frame_mode_select ? `U89_FRAME9_LAST : `U89_FRAME8_LAST;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            txState        <= TX_IDLE;
            txShift        <= '1;
            txCount        <= '0;
            serial_out_pin <= 1'b1;
            txDoneSet      <= 1'b0;
        end else begin
            txDoneSet <= 1'b0;
            case (txState)
                TX_IDLE: begin
                    serial_out_pin <= 1'b1;
                    if (cpu.dataWr) begin
                        txShift <= {1'b1, tx_ninth_bit, cpu.wrData};
                        if (!frame_mode_select) txShift[8] <= 1'b1;
                        txState <= TX_WAIT;
                    end
                end
                TX_WAIT: if (txBitTick) begin
                    serial_out_pin <= 1'b0; // start bit
                    txCount        <= '0;
                    txState        <= TX_SHIFT;
                end
                TX_SHIFT: if (txBitTick) begin
                    if (txCount == txLast - 4'h1) begin
                        // stop bit begins here, so the flag rises with it
                        serial_out_pin <= 1'b1;
                        txDoneSet      <= 1'b1;
                        txState        <= TX_IDLE;
                    end else begin
                        serial_out_pin <= txShift[0];
                        txShift        <= {1'b1, txShift[9:1]};
                        txCount        <= txCount + 4'h1;
                    end
                end
                default: txState <= TX_IDLE;
            endcase
        end
    end

    // ==========================================================
    // receiver
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_SHIFT} uart89_rx_e;
    uart89_rx_e rxState;
    logic [7:0] rxShift;
    logic [3:0] rxCount;
    logic [3:0] rxBits;
    logic       rxLinePrev;
    logic       rxFrameEnd;
    logic       rxNinth;
    logic       rxAccept;
    // falling edge of an idle line while enabled
    assign startSeen = (rxState == RX_IDLE) && rx_enable && rxLinePrev && !rxLine;
    // the cell after the data bits (stop in 8-bit, ninth in 9-bit) ends the frame
    assign rxBits     = `U89_DATA_BITS;
    assign rxFrameEnd = (rxState == RX_SHIFT) && rxHalfTick && (rxCount == rxBits);
    // judged as it is sampled, so the line is free again before the stop ends
    assign rxNinth    = rxLine;
    assign rxNinthNew = rxNinth;
    assign rxAccept   = !rx_done_flag && (!multiproc_enable || rxNinth);
    assign rxLoad     = rxFrameEnd && rxAccept;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rxState    <= RX_IDLE;
            rxShift    <= '0;
            rxCount    <= '0;
            rxLinePrev <= 1'b1;
        end else begin
            rxLinePrev <= rxLine;
            case (rxState)
                RX_IDLE: if (startSeen) begin
                    rxCount <= '0;
                    rxState <= RX_START;
                end
                RX_START: if (rxHalfTick) begin
                    // false start: line back high at mid-bit
                    rxState <= rxLine ? RX_IDLE : RX_SHIFT;
                end
                RX_SHIFT: if (rxHalfTick) begin
                    // 9-bit mode samples the ninth bit; the stop cell is skipped
                    rxShift <= {rxLine, rxShift[7:1]};
                    rxCount <= rxCount + 4'h1;
                    if (rxCount == rxBits) rxState <= RX_IDLE;
                end
                default: rxState <= RX_IDLE;
            endcase
        end
    end

    // ==========================================================
    // receive buffer; shifter is free again after each frame
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            serial_data_buffer <= '0;
        end else if (rxLoad) begin
            // a full buffer blocks the load, keeping the first byte
            serial_data_buffer <= rxShift;
        end
    end

    // ==========================================================
    // status view and interrupt
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            serial_control_reg <= `U89_CTRL_RESET;
            serialIrq          <= 1'b0;
        end else begin
            serial_control_reg <= {frame_mode_select, 1'b1, multiproc_enable, rx_enable,
                                   tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};
            serialIrq          <= intEnable && (tx_done_flag || rx_done_flag);
        end
    end

    // ==========================================================
    // checks
    sequence frame_done_s;
        rxFrameEnd && !rx_done_flag;
    endsequence
    rx_load_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        rxLoad |-> !rx_done_flag) else $error("load while flag set");
    mp_filter_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rxLoad && multiproc_enable) |-> rxNinth) else $error("mp filter broken");
    rx_flag_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        rxLoad |=> rx_done_flag) else $error("rx flag not set");
    overrun_keep_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rx_done_flag && !cpu.ctrlWr) |=> $stable(serial_data_buffer)) else
        $error("buffer overwritten");
    idle_high_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (txState == TX_IDLE) |=> serial_out_pin || (txState != TX_IDLE)) else
        $error("line not idle high");
    tx_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        txDoneSet |=> tx_done_flag) else $error("tx flag missed");
    stop_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        txDoneSet |-> serial_out_pin) else $error("flag not at stop bit");
    flag_sticky_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (tx_done_flag && !cpu.ctrlWr) |=> tx_done_flag) else $error("flag self cleared");
    irq_follow_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (intEnable && rx_done_flag) |=> serialIrq) else $error("irq missing");
    start_reload_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        startSeen |=> (rxTimer == $past(baud.reload))) else $error("no reload");
    rx_disabled_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !rx_enable |-> !startSeen) else $error("rx while disabled");
    frame_load_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        frame_done_s and (!multiproc_enable) |-> rxLoad) else $error("frame dropped");
    ninth_store_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        rxLoad |=> (rx_ninth_bit == $past(rxLine))) else $error("ninth bit not stored");
endmodule // uart89_serial_port

// ---- verif/uart89_peer_model.sv ----
// remote serial peer: sends frames into the port, decodes frames leaving it
// assumes the bench sets bitClks and nineBits before each transfer
module uart89_peer_model (
    // clock
    input  wire logic clk_sys,
    // serial lines
    input  wire logic lineIn,
    output logic      lineOut
);
    timeunit 1ns;
    timeprecision 1ps;
    int         bitClks = 16;
    logic       nineBits = 1'b0;
    logic       rxBusy = 1'b0;
    logic [7:0] gotData;
    logic       gotNinth;
    logic       gotStop;
    // ==========================================================
    // sender: a line we own idles high between frames
    initial lineOut = 1'b1;
    task automatic sendFrame(input logic [7:0] d, input logic ninth, input logic stop);
        logic [10:0] bits;
        int          n;
        bits = {stop, ninth, d, 1'b0};
        n = nineBits ? 11 : 10;
        if (!nineBits) begin
            bits[9] = stop;
        end
        for (int i = 0; i < n; i++) begin
            @(negedge clk_sys);
            lineOut = bits[i];
            repeat (bitClks - 1) @(negedge clk_sys);
        end
        @(negedge clk_sys);
        lineOut = 1'b1;
    endtask
    // receiver: samples mid-bit, timed from the falling start edge only
    always begin
        @(negedge lineIn);
        rxBusy = 1'b1;
        repeat (bitClks / 2) @(negedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (bitClks) @(negedge clk_sys);
            gotData[i] = lineIn;
        end
        if (nineBits) begin
            repeat (bitClks) @(negedge clk_sys);
            gotNinth = lineIn;
        end
        repeat (bitClks) @(negedge clk_sys);
        gotStop = lineIn;
        rxBusy = 1'b0;
    end
endmodule // uart89_peer_model

// ---- verif/uart89_serial_port_tb.sv ----
// self-checking bench: serial port against a remote peer, random bytes, corner cases
// assumes the design package and the peer model are compiled before this file
module uart89_serial_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import uart89_pkg::*;
    logic         clk_sys = 1'b0;
    logic         resetn = 1'b0;
    uart89_cpu_s  cpu = '0;
    uart89_baud_s baud = '{1'b1, SRC_SYS, 8'hf8};
    logic         intEnable = 1'b0;
    logic         xoscClk = 1'b0;
    logic         extClk = 1'b0;
    logic [7:0]   ctrlView;
    logic [7:0]   dataBuf;
    logic         irq;
    logic         rxPin;
    logic         txPin;
    logic [15:0]  lfsr = 16'h4629;
    logic [7:0]   d1;
    logic [7:0]   d2;
    int           divTab[6] = '{1, 4, 12, 48, 16, 4};
    int           mismatches = 0;
    int           comparisons = 0;
    // ==========================================================
    // design and peer
    uart89_serial_port uart89_serial_port_inst (
        .clk_sys(clk_sys), .resetn(resetn), .cpu(cpu), .baud(baud),
        .intEnable(intEnable), .serial_control_reg(ctrlView),
        .serial_data_buffer(dataBuf), .serialIrq(irq), .serial_in_pin(rxPin),
        .baud_timer_ext_input(extClk), .xoscClk(xoscClk), .serial_out_pin(txPin)
    );
    uart89_peer_model peer (.clk_sys(clk_sys), .lineIn(txPin), .lineOut(rxPin));
    // clocks: oscillator 2 and external input 4 system periods, phase offset on purpose
    initial forever #25 clk_sys = ~clk_sys;
    initial #7 forever #50 xoscClk = ~xoscClk;
    initial #13 forever #100 extClk = ~extClk;
    // ==========================================================
    // helpers
    function automatic logic [7:0] nextRand();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t ns %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chkBit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t ns %s: got %b expected %b", $time, what, got, exp);
        end
    endtask
    // control write also clears flags, so callers rewrite the whole word
    task automatic ctrlWrite(input logic [7:0] v);
        @(negedge clk_sys);
        cpu.ctrlWr = 1'b1;
        cpu.wrData = v;
        @(negedge clk_sys);
        cpu.ctrlWr = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk8(ctrlView, {v[7], 1'b1, v[5:0]}, "control view");
    endtask
    // bit length in system clocks follows from source divide and reload byte
    task automatic setBaud(input uart89_src_e s, input logic [7:0] r);
        @(negedge clk_sys);
        baud.src = s;
        baud.reload = r;
        peer.bitClks = 2 * (256 - int'(r)) * divTab[int'(s)];
        repeat (2 * peer.bitClks) @(negedge clk_sys);
    endtask
    task automatic txCheck(input logic [7:0] ctrl, input logic [7:0] d);
        int n;
        ctrlWrite(ctrl);
        cpu.dataWr = 1'b1;
        cpu.wrData = d;
        @(negedge clk_sys);
        cpu.dataWr = 1'b0;
        n = 0;
        while (ctrlView[1] !== 1'b1 && n < 20000) begin
            @(negedge clk_sys);
            n++;
        end
        chkBit(txPin, 1'b1, "stop level at flag");
        chkBit(peer.rxBusy, 1'b1, "flag before stop ends");
        chkBit(irq, intEnable, "tx irq");
        while (peer.rxBusy === 1'b1 && n < 20000) begin
            @(negedge clk_sys);
            n++;
        end
        chkBit(n < 20000, 1'b1, "tx frame timeout");
        chk8(peer.gotData, d, "tx data");
        chkBit(peer.gotStop, 1'b1, "tx stop");
        if (peer.nineBits) begin
            chkBit(peer.gotNinth, ctrl[3], "tx ninth");
        end
        repeat (peer.bitClks) @(negedge clk_sys);
    endtask
    task automatic recv(input logic [7:0] d, input logic ninth, input logic stop);
        peer.sendFrame(d, ninth, stop);
        repeat (peer.bitClks) @(negedge clk_sys);
    endtask
    task automatic end_sim();
        if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ==========================================================
    // watchdog: the source sweep dominates, well under 80000 cycles
    initial begin
        #4000000;
        mismatches++;
        $display("[ERR] %0t ns watchdog expired", $time);
        end_sim();
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        resetn = 1'b1;
        chk8(ctrlView, 8'h40, "control reset");
        chk8(dataBuf, 8'h00, "buffer reset");
        chkBit(txPin, 1'b1, "idle line");
        chkBit(irq, 1'b0, "irq reset");
        intEnable = 1'b1;
        setBaud(SRC_SYS, 8'hf8);
        repeat (3) txCheck(8'h10, nextRand());
        cpu.dataRd = 1'b1;
        @(negedge clk_sys);
        cpu.dataRd = 1'b0;
        @(negedge clk_sys);
        chkBit(ctrlView[1], 1'b1, "tx flag held");
        ctrlWrite(8'h10);
        chkBit(irq, 1'b0, "irq after clear");
        // 8-bit receive, overrun, then a frame overlapping the pending byte
        d1 = nextRand();
        recv(d1, 1'b0, 1'b1);
        chk8(dataBuf, d1, "rx byte");
        chkBit(ctrlView[2], 1'b1, "stop stored");
        chkBit(irq, 1'b1, "rx irq");
        recv(nextRand(), 1'b0, 1'b1);
        chk8(dataBuf, d1, "overrun keeps first");
        d2 = nextRand();
        fork
            recv(d2, 1'b0, 1'b1);
            begin
                repeat (3 * peer.bitClks) @(negedge clk_sys);
                ctrlWrite(8'h10);
            end
        join
        chk8(dataBuf, d2, "byte behind buffer");
        ctrlWrite(8'h30);
        recv(nextRand(), 1'b0, 1'b0);
        chkBit(ctrlView[0], 1'b0, "bad stop refused");
        chk8(dataBuf, d2, "buffer kept");
        ctrlWrite(8'h00);
        recv(nextRand(), 1'b0, 1'b1);
        chkBit(ctrlView[0], 1'b0, "rx disabled");
        chk8(dataBuf, d2, "disabled keeps buffer");
        // a stopped baud timer holds a written byte until it runs again
        baud.timerRun = 1'b0;
        d1 = nextRand();
        cpu.dataWr = 1'b1;
        cpu.wrData = d1;
        @(negedge clk_sys);
        cpu.dataWr = 1'b0;
        repeat (4 * peer.bitClks) @(negedge clk_sys);
        chkBit(txPin, 1'b1, "line idle while timer stopped");
        chkBit(ctrlView[1], 1'b0, "no flag while timer stopped");
        baud.timerRun = 1'b1;
        repeat (12 * peer.bitClks) @(negedge clk_sys);
        chk8(peer.gotData, d1, "held byte sent");
        chkBit(ctrlView[1], 1'b1, "held byte flag");
        // 9-bit mode: ninth bit both ways, then address filtering
        peer.nineBits = 1'b1;
        txCheck(8'h98, nextRand());
        txCheck(8'h90, nextRand());
        ctrlWrite(8'h90);
        d1 = nextRand();
        recv(d1, 1'b0, 1'b0);
        chk8(dataBuf, d1, "nine-bit byte");
        chkBit(ctrlView[2], 1'b0, "ninth stored");
        ctrlWrite(8'hb0);
        recv(nextRand(), 1'b0, 1'b1);
        chkBit(ctrlView[0], 1'b0, "data frame filtered");
        chkBit(irq, 1'b0, "no irq on data");
        d2 = nextRand();
        recv(d2, 1'b1, 1'b1);
        chk8(dataBuf, d2, "address byte");
        chkBit(irq, 1'b1, "irq on address");
        intEnable = 1'b0;
        repeat (2) @(negedge clk_sys);
        chkBit(irq, 1'b0, "irq masked");
        // every timer clock source, both directions
        intEnable = 1'b1;
        peer.nineBits = 1'b0;
        for (int s = 0; s < 6; s++) begin
            setBaud(uart89_src_e'(s), 8'hfa);
            txCheck(8'h10, nextRand());
            d1 = nextRand();
            recv(d1, 1'b0, 1'b1);
            chk8(dataBuf, d1, "rx per source");
        end
        end_sim();
    end
endmodule // uart89_serial_port_tb
